// ==== rtl/chss_pkg.sv ====
package chss_pkg;

  // Frequencies are held in units of 0.01 Hz
  localparam int          FREQ_W          = 16;
  localparam int          PRESET_N        = 8;
  localparam logic [15:0] FREQ_MAX        = 16'h9C40;  // 400 Hz
  localparam logic [15:0] HOLD_FREQ_CAP   = 16'h0BB8;  // 30 Hz
  localparam logic [15:0] CARRIER_FREQ_TH = 16'h012C;  // 3 Hz
  localparam logic [15:0] SETTING_OFF     = 16'h270F;  // 9999
  localparam logic [15:0] STALL_MAX       = 16'h00C8;  // 200 %
  localparam logic [15:0] EXCITE_MAX      = 16'h012C;  // 300 %
  localparam logic [15:0] EXCITE_UNITY    = 16'h0064;  // 100 %
  localparam logic [15:0] CARRIER_MAX     = 16'h0009;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PRESET  = 8'h04;  // 8 words, 0x04..0x20
  localparam logic [7:0] OFS_STALL   = 8'h24;
  localparam logic [7:0] OFS_EXCITE  = 8'h28;
  localparam logic [7:0] OFS_CARRIER = 8'h2C;
  localparam logic [7:0] OFS_STATUS  = 8'h30;

  // Control register fields
  localparam int CTRL_HOLD_EN   = 0;
  localparam int CTRL_REMOTE_LO = 1;   // two bits
  localparam int CTRL_PANEL     = 3;
  localparam int CTRL_COMBINED  = 4;
  localparam int CTRL_PID       = 5;
  localparam int CTRL_AUTO_ACC  = 6;
  localparam int CTRL_WRSEL_LO  = 8;   // two bits
  localparam logic [1:0] WRSEL_RUN_OK = 2'h2;

  // Preset slots
  localparam logic [2:0] IDX_LOW  = 3'h0;
  localparam logic [2:0] IDX_MID  = 3'h1;
  localparam logic [2:0] IDX_HIGH = 3'h2;
  localparam logic [2:0] IDX_S4   = 3'h3;
  localparam logic [2:0] IDX_S5   = 3'h4;
  localparam logic [2:0] IDX_S6   = 3'h5;
  localparam logic [2:0] IDX_S7   = 3'h6;
  localparam logic [2:0] IDX_JOG  = 3'h7;

  // Reset values
  localparam logic [15:0] RST_LOW_SPEED = 16'h03E8;  // 10 Hz
  localparam logic [15:0] RST_PRESET    = 16'h0000;
  localparam logic [15:0] RST_NORM_STALL = 16'h0096; // 150 %
  localparam logic [15:0] RST_SEC_STALL = 16'h270F;
  localparam logic [15:0] RST_EXCITE    = 16'h270F;
  localparam logic [3:0]  RST_NORM_CARR = 4'h1;
  localparam logic [15:0] RST_CONT_CARR = 16'h270F;

  typedef enum logic [3:0] {
    CHSS_SRC_ANALOG, CHSS_SRC_LOW, CHSS_SRC_MID, CHSS_SRC_HIGH,
    CHSS_SRC_S4, CHSS_SRC_S5, CHSS_SRC_S6, CHSS_SRC_S7, CHSS_SRC_JOG
  } chss_src_e;

  function automatic logic [2:0] chss_src_idx(input chss_src_e s);
    unique case (s)
      CHSS_SRC_LOW:  chss_src_idx = IDX_LOW;
      CHSS_SRC_MID:  chss_src_idx = IDX_MID;
      CHSS_SRC_HIGH: chss_src_idx = IDX_HIGH;
      CHSS_SRC_S4:   chss_src_idx = IDX_S4;
      CHSS_SRC_S5:   chss_src_idx = IDX_S5;
      CHSS_SRC_S6:   chss_src_idx = IDX_S6;
      CHSS_SRC_S7:   chss_src_idx = IDX_S7;
      CHSS_SRC_JOG:  chss_src_idx = IDX_JOG;
      default:       chss_src_idx = IDX_LOW;
    endcase
  endfunction

endpackage

// ==== rtl/chss_sel_if.sv ====
interface chss_sel_if;
  logic      high;
  logic      mid;
  logic      low;
  logic      second;
  logic      jog;
  logic      hold_allowed;
  chss_pkg::chss_src_e src;
  logic      hold_req;

  modport top (output high, mid, low, second, jog, hold_allowed,
               input  src, hold_req);
  modport dec (input  high, mid, low, second, jog, hold_allowed,
               output src, hold_req);
endinterface

// ==== rtl/chss_speed_decode.sv ====
module chss_speed_decode
  import chss_pkg::*;
(
  chss_sel_if.dec sel
);

  always_comb begin
    sel.hold_req = 1'b0;
    if (sel.jog) begin
      sel.src = CHSS_SRC_JOG;  // [R13]
    end else if (sel.low && sel.second) begin
      sel.src      = CHSS_SRC_LOW;  // [R14]
      sel.hold_req = sel.hold_allowed;  // [R02]
    end else if (!sel.low) begin
      // Without low, second function steers neither the hold entry nor the speed
      unique case ({sel.high, sel.mid})  // [R16]
        2'b11:   sel.src = CHSS_SRC_S6;
        2'b10:   sel.src = CHSS_SRC_HIGH;  // [R18]
        2'b01:   sel.src = CHSS_SRC_MID;   // [R18]
        default: sel.src = CHSS_SRC_ANALOG;  // [R15]
      endcase
    end else begin
      unique case ({sel.high, sel.mid})  // [R17]
        2'b11:   sel.src = CHSS_SRC_S7;
        2'b10:   sel.src = CHSS_SRC_S5;
        2'b01:   sel.src = CHSS_SRC_S4;
        default: sel.src = CHSS_SRC_LOW;  // [R18]
      endcase
    end
  end

endmodule // chss_speed_decode

// ==== rtl/chss_top.sv ====
// Contract
// [R01] Hold-select setting: 0 normal, 1 stop-on-contact; resets to 0.
// [R02] Enabled: hold begins once low-speed and second-function both asserted.
// [R03] Either of those inputs released returns to normal operation.
// [R04] Hold runs at the low-speed setting, whatever speed came before.
// [R05] Low-speed setting 0..400 Hz, default 10 Hz; hold caps it at 30 Hz.
// [R06] Hold uses second stall level 0..200 %; 9999 falls back to normal.
// [R07] Excitation multiplier 0..300 % applies only in hold; 9999 disables.
// [R08] Hold carrier used only at 3 Hz or below; 9999 uses normal.
// [R09] Excitation multiplier writable while running even with write select 0.
// [R10] Controller sets external mode and flux vector control before use.
// [R11] Panel, jog, combined, PID, remote or auto-accel modes block hold.
// [R12] Remote setting selection 1 to 3 blocks hold.
// [R13] Jog input selects jog frequency over every other input.
// [R14] Low-speed plus second-function selects low speed, high/mid ignored.
// [R15] Second-function alone or no inputs selects the analog input.
// [R16] Without low/jog, second ignored; high, mid, both give high/mid/6.
// [R17] With low, no second: all three speed 7, high 5, mid 4.
// [R18] Single high, mid or low input selects that multi-speed setting.
// [R19] Selection and mode outputs are registered, one cycle after inputs; pin inputs take two more cycles through the synchronisers.
module chss_top
  import chss_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        high_speed_select_in_i,
  input  wire logic        mid_speed_select_in_i,
  input  wire logic        low_speed_select_in_i,
  input  wire logic        second_function_in_i,
  input  wire logic        jog_select_in_i,
  input  wire logic        running_i,
  input  wire logic [15:0] analog_freq_i,
  input  wire logic [15:0] output_freq_i,
  output logic      [15:0] freq_cmd_o,
  output chss_src_e        freq_src_o,
  output logic             contact_hold_o,
  output logic      [15:0] stall_level_o,
  output logic      [15:0] excitation_mult_o,
  output logic             excitation_comp_o,
  output logic       [3:0] carrier_o,
  output logic             fast_limit_en_o
);

  // Contact pins: two-stage synchronisers, stage one read only by stage two
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] next_pin_meta;
  logic [4:0] next_pin_sync;

  always_comb begin
    next_pin_meta = {jog_select_in_i, second_function_in_i,
                     low_speed_select_in_i, mid_speed_select_in_i,
                     high_speed_select_in_i};
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
    end
  end

  // Register file
  logic [9:0]  ctrl;
  logic [15:0] preset [PRESET_N];
  logic [15:0] norm_stall;
  logic [15:0] sec_stall;
  logic [15:0] excite;
  logic [3:0]  norm_carr;
  logic [15:0] cont_carr;
  logic [9:0]  next_ctrl;
  logic [15:0] next_preset [PRESET_N];
  logic [15:0] next_norm_stall;
  logic [15:0] next_sec_stall;
  logic [15:0] next_excite;
  logic [3:0]  next_norm_carr;
  logic [15:0] next_cont_carr;
  logic [31:0] next_dat;
  logic        next_ack;
  logic [31:0] wr_word;
  logic        wr_go;
  logic        wr_cfg_ok;

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] max,
                                    input logic        off_ok);
    return (v <= max) || (off_ok && v == SETTING_OFF);
  endfunction

  // Status word assembled from registered outputs
  logic [31:0] status_word;
  assign status_word = {20'h0_0000, fast_limit_en_o, excitation_comp_o,
                        contact_hold_o, 5'h00, 4'(freq_src_o)};

  always_comb begin
    next_ack        = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr_go           = next_ack && wb_we_i;
    // Settings other than the excitation multiplier are frozen while running unless write select is 2
    wr_cfg_ok       = !running_i ||
                      (ctrl[CTRL_WRSEL_LO +: 2] == WRSEL_RUN_OK);
    next_ctrl       = ctrl;
    next_preset     = preset;
    next_norm_stall = norm_stall;
    next_sec_stall  = sec_stall;
    next_excite     = excite;
    next_norm_carr  = norm_carr;
    next_cont_carr  = cont_carr;
    next_dat        = 32'h0000_0000;
    wr_word         = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_CTRL: begin
        next_dat = {22'h00_0000, ctrl};
        wr_word  = lane_merge(next_dat, wb_dat_i, wb_sel_i);
        if (wr_go && wr_cfg_ok) begin
          next_ctrl = wr_word[9:0];  // [R01]
        end
      end
      OFS_STALL: begin
        next_dat = {sec_stall, norm_stall};
        wr_word  = lane_merge(next_dat, wb_dat_i, wb_sel_i);
        if (wr_go && wr_cfg_ok &&
            in_range(wr_word[15:0], STALL_MAX, 1'b0) &&
            in_range(wr_word[31:16], STALL_MAX, 1'b1)) begin
          next_norm_stall = wr_word[15:0];
          next_sec_stall  = wr_word[31:16];  // [R06]
        end
      end
      OFS_EXCITE: begin
        next_dat = {16'h0000, excite};
        wr_word  = lane_merge(next_dat, wb_dat_i, wb_sel_i);
        if (wr_go && in_range(wr_word[15:0], EXCITE_MAX, 1'b1)) begin
          next_excite = wr_word[15:0];  // [R07] [R09]
        end
      end
      OFS_CARRIER: begin
        next_dat = {cont_carr, 12'h000, norm_carr};
        wr_word  = lane_merge(next_dat, wb_dat_i, wb_sel_i);
        if (wr_go && wr_cfg_ok &&
            in_range({12'h000, wr_word[3:0]}, CARRIER_MAX, 1'b0) &&
            in_range(wr_word[31:16], CARRIER_MAX, 1'b1)) begin
          next_norm_carr = wr_word[3:0];
          next_cont_carr = wr_word[31:16];  // [R08]
        end
      end
      OFS_STATUS: begin
        next_dat = status_word;
      end
      default: begin
        // Preset window; any other address reads zero and ignores writes
        for (int i = 0; i < PRESET_N; i++) begin
          if (wb_adr_i == OFS_PRESET + 8'(i * 4)) begin
            next_dat = {16'h0000, preset[i]};
            wr_word  = lane_merge(next_dat, wb_dat_i, wb_sel_i);
            if (wr_go && wr_cfg_ok &&
                in_range(wr_word[15:0], FREQ_MAX, 1'b0)) begin
              next_preset[i] = wr_word[15:0];  // [R05]
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl       <= 10'h000;  // [R01]
      norm_stall <= RST_NORM_STALL;
      sec_stall  <= RST_SEC_STALL;
      excite     <= RST_EXCITE;
      norm_carr  <= RST_NORM_CARR;
      cont_carr  <= RST_CONT_CARR;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      for (int i = 0; i < PRESET_N; i++) begin
        preset[i] <= (3'(i) == IDX_LOW) ? RST_LOW_SPEED : RST_PRESET;  // [R05]
      end
    end else begin
      ctrl       <= next_ctrl;
      preset     <= next_preset;
      norm_stall <= next_norm_stall;
      sec_stall  <= next_sec_stall;
      excite     <= next_excite;
      norm_carr  <= next_norm_carr;
      cont_carr  <= next_cont_carr;
      wb_ack_o   <= next_ack;
      wb_dat_o   <= next_dat;
    end
  end

  // Speed source decode
  chss_sel_if sel_bus ();
  logic blocked;

  // External mode and flux vector control are the controller's duty
  always_comb begin
    blocked = ctrl[CTRL_PANEL] || ctrl[CTRL_COMBINED] || ctrl[CTRL_PID] ||
              ctrl[CTRL_AUTO_ACC] ||
              (ctrl[CTRL_REMOTE_LO +: 2] != 2'h0);  // [R11] [R12]
    sel_bus.high         = pin_sync[0];
    sel_bus.mid          = pin_sync[1];
    sel_bus.low          = pin_sync[2];
    sel_bus.second       = pin_sync[3];
    sel_bus.jog          = pin_sync[4];  // [R11]
    sel_bus.hold_allowed = ctrl[CTRL_HOLD_EN] && !blocked;
  end

  chss_speed_decode u_decode (
    .sel (sel_bus.dec)
  );

  // Output selection
  logic [15:0] next_freq;
  chss_src_e   next_src;
  logic        next_hold;
  logic [15:0] next_stall;
  logic [15:0] next_exc_mult;
  logic        next_exc_comp;
  logic [3:0]  next_carrier;
  logic [15:0] low_set;

  always_comb begin
    next_hold = sel_bus.hold_req;  // [R02] [R03]
    next_src  = sel_bus.src;
    low_set   = preset[IDX_LOW];
    if (next_src == CHSS_SRC_ANALOG) begin
      next_freq = analog_freq_i;
    end else begin
      next_freq = preset[chss_src_idx(next_src)];
    end
    if (next_hold) begin
      // Capped to keep holding torque without driving into the stopper
      next_freq = (low_set > HOLD_FREQ_CAP) ? HOLD_FREQ_CAP :  // [R05]
                  low_set;  // [R04]
    end
    next_stall = (next_hold && sec_stall != SETTING_OFF) ?
                 sec_stall : norm_stall;  // [R06]
    next_exc_comp = next_hold && excite != SETTING_OFF;  // [R07]
    next_exc_mult = next_exc_comp ? excite : EXCITE_UNITY;
    next_carrier  = norm_carr;
    if (next_hold && cont_carr != SETTING_OFF &&
        output_freq_i <= CARRIER_FREQ_TH) begin
      next_carrier = cont_carr[3:0];  // [R08]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_cmd_o        <= 16'h0000;
      freq_src_o        <= CHSS_SRC_ANALOG;
      contact_hold_o    <= 1'b0;
      stall_level_o     <= RST_NORM_STALL;
      excitation_mult_o <= EXCITE_UNITY;
      excitation_comp_o <= 1'b0;
      carrier_o         <= RST_NORM_CARR;
      fast_limit_en_o   <= 1'b1;
    end else begin
      freq_cmd_o        <= next_freq;  // [R19]
      freq_src_o        <= next_src;
      contact_hold_o    <= next_hold;
      stall_level_o     <= next_stall;
      excitation_mult_o <= next_exc_mult;
      excitation_comp_o <= next_exc_comp;
      carrier_o         <= next_carrier;
      fast_limit_en_o   <= !next_hold;
    end
  end

endmodule // chss_top

// ==== verification/chss_contact_model.sv ====
module chss_contact_model
(
  input  wire logic       clk_i,
  input  wire logic [4:0] cmd_i,
  output logic      [4:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Relay contacts: {high, mid, low, second, jog}, open at power-up
  initial pins_o = 5'h00;
  // Controller in external mode moves contacts just after an edge
  always @(posedge clk_i) begin
    pins_o <= cmd_i;
  end
endmodule // chss_contact_model

// ==== verification/chss_top_checker.sv ====
module chss_top_checker
  import chss_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        low_speed_select_in_i,
  input wire logic        second_function_in_i,
  input wire logic        jog_select_in_i,
  input wire logic [15:0] analog_freq_i,
  input wire logic [15:0] freq_cmd_o,
  input wire chss_src_e   freq_src_o,
  input wire logic        contact_hold_o,
  input wire logic [15:0] excitation_mult_o,
  input wire logic        excitation_comp_o,
  input wire logic        fast_limit_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ACK_PULSE: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a one-cycle answer");
  // Pins take two sync stages plus the output register
  AST_LOW_OFF: assert property
    ((!low_speed_select_in_i) [*3] |=> !contact_hold_o)
    else $error("hold while low-speed input is off");
  AST_SEC_OFF: assert property
    ((!second_function_in_i) [*3] |=> !contact_hold_o)
    else $error("hold while second-function input is off");
  AST_JOG_WINS: assert property
    (jog_select_in_i [*3] |=> freq_src_o == CHSS_SRC_JOG && !contact_hold_o)
    else $error("jog input not selecting jog frequency");
  AST_HOLD_FREQ: assert property
    (contact_hold_o |-> freq_src_o == CHSS_SRC_LOW
                        && freq_cmd_o <= HOLD_FREQ_CAP)
    else $error("hold frequency not the capped low speed");
  AST_FAST_LIMIT: assert property
    (fast_limit_en_o != contact_hold_o)
    else $error("fast limit state disagrees with hold state");
  AST_EXCITE_OFF: assert property
    (!contact_hold_o |-> !excitation_comp_o
                         && excitation_mult_o == EXCITE_UNITY)
    else $error("excitation compensation outside hold");
  AST_ANALOG: assert property
    (freq_src_o == CHSS_SRC_ANALOG && !$past(rst_i)
     |-> freq_cmd_o == $past(analog_freq_i))
    else $error("analog source not passed to frequency");
endmodule // chss_top_checker

bind chss_top chss_top_checker u_checker (.*);

// ==== verification/testbench.sv ====
module testbench
  import chss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0]  wb_sel_i = 4'hf;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        running_i = 1'b0;
  logic [15:0] analog_freq_i = 16'h0777;
  logic [15:0] output_freq_i = 16'h012C;
  logic [4:0]  pin_cmd = 5'h00;
  logic [4:0]  pins;
  logic        high_speed_select_in_i, mid_speed_select_in_i;
  logic        low_speed_select_in_i, second_function_in_i, jog_select_in_i;
  logic [31:0] wb_dat_o, rdat;
  logic        wb_ack_o, contact_hold_o, excitation_comp_o, fast_limit_en_o;
  logic [15:0] freq_cmd_o, stall_level_o, excitation_mult_o, f;
  logic [3:0]  carrier_o;
  chss_src_e   freq_src_o, s;
  logic        h;
  int          error_cnt = 0;
  int          n_compared = 0;
  logic [15:0] pv [8] = '{16'h1388, 16'h0200, 16'h0400, 16'h0600,
                          16'h0800, 16'h0A00, 16'h0C00, 16'h0E00};
  chss_src_e   tbl [8] = '{CHSS_SRC_ANALOG, CHSS_SRC_LOW, CHSS_SRC_MID,
                           CHSS_SRC_S4, CHSS_SRC_HIGH, CHSS_SRC_S5,
                           CHSS_SRC_S6, CHSS_SRC_S7};
  logic [7:0]  radr [6] = '{8'h00, 8'h04, 8'h24, 8'h28, 8'h2C, 8'hFC};
  logic [31:0] rexp [6] = '{32'h0, 32'h03E8, 32'h270F_0096, 32'h270F,
                           32'h270F_0001, 32'h0};
  logic [31:0] blk [8] = '{32'h0, 32'h3, 32'h5, 32'h7, 32'h9, 32'h11,
                          32'h21, 32'h41};

  chss_top DUT (.*);
  chss_contact_model u_contacts (.clk_i(clk_i), .cmd_i(pin_cmd),
                                 .pins_o(pins));
  assign {high_speed_select_in_i, mid_speed_select_in_i,
          low_speed_select_in_i, second_function_in_i,
          jog_select_in_i} = pins;

  initial forever #4 clk_i = ~clk_i;

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= 32'(d);
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 20) begin
      error_cnt++;
      test_done();
    end
  endtask

  // Model edge, two sync edges, output edge, then sample
  task automatic pins_set(input logic [4:0] p);
    @(posedge clk_i);
    pin_cmd <= p;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic hold_chk(input logic [15:0] st, mu, input logic [3:0] ca);
    repeat (2) @(posedge clk_i);
    check("stall", 32'(stall_level_o), 32'(st));
    check("mult", 32'(excitation_mult_o), 32'(mu));
    check("carrier", 32'(carrier_o), 32'(ca));
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, radr[k], 0);
      check("reset reg", rdat, rexp[k]);
    end
    for (int k = 0; k < 8; k++)
      bus(1'b1, 8'(8'h04 + 4 * k), 32'(pv[k]));
    bus(1'b1, 8'h04, 32'h0000_9C41);
    bus(1'b0, 8'h04, 0);
    check("low range", rdat, 32'h1388);
    bus(1'b1, 8'h00, 1);
    for (int p = 0; p < 32; p++) begin
      // A moving analog value proves the analog path is really followed
      analog_freq_i <= 16'h0700 + 16'(p);
      pins_set(5'(p));
      h = !p[0] && p[2] && p[1];
      s = p[0] ? CHSS_SRC_JOG : h ? CHSS_SRC_LOW : tbl[p[4:2]];
      f = (s == CHSS_SRC_ANALOG) ? analog_freq_i :
          h ? HOLD_FREQ_CAP : pv[int'(s) - 1];
      check("src", freq_src_o, s);
      check("freq", 32'(freq_cmd_o), 32'(f));
      check("hold", 32'(contact_hold_o), 32'(h));
    end
    pins_set(5'b00110);
    bus(1'b1, 8'h24, 32'h270F_0078);
    bus(1'b1, 8'h2C, 32'h0007_0003);
    hold_chk(16'h0078, 16'h0064, 4'h7);
    bus(1'b1, 8'h24, 32'h0032_0078);
    bus(1'b1, 8'h28, 32'h0096);
    hold_chk(16'h0032, 16'h0096, 4'h7);
    check("comp", 32'(excitation_comp_o), 32'h1);
    output_freq_i <= 16'h012D;
    hold_chk(16'h0032, 16'h0096, 4'h3);
    output_freq_i <= 16'h012C;
    bus(1'b1, 8'h2C, 32'h270F_0003);
    hold_chk(16'h0032, 16'h0096, 4'h3);
    pins_set(5'b00100);
    hold_chk(16'h0078, 16'h0064, 4'h3);
    pins_set(5'b00110);
    foreach (blk[k]) begin
      bus(1'b1, 8'h00, blk[k] | 32'h1);
      repeat (2) @(posedge clk_i);
      check("hold blk", 32'(contact_hold_o), 32'(k == 0));
    end
    bus(1'b1, 8'h00, 0);
    repeat (2) @(posedge clk_i);
    check("hold off", 32'(contact_hold_o), 32'h0);
    running_i <= 1'b1;
    bus(1'b1, 8'h28, 32'h00A0);
    bus(1'b0, 8'h28, 0);
    check("excite run", rdat, 32'h00A0);
    bus(1'b1, 8'h24, 0);
    bus(1'b0, 8'h24, 0);
    check("stall run", rdat, 32'h0032_0078);
    // Run writes only open once write select is set while stopped
    running_i <= 1'b0;
    bus(1'b1, 8'h00, 32'h0000_0200);
    running_i <= 1'b1;
    bus(1'b1, 8'h24, 32'h0000_0064);
    bus(1'b0, 8'h24, 0);
    check("stall wrsel", rdat, 32'h0000_0064);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(1'b0, 8'h30, 0);
    check("status", rdat, 32'h0000_0801);
    bus(1'b0, 8'h24, 0);
    check("stall rst", rdat, 32'h270F_0096);
    test_done();
  end
endmodule // testbench
